// ==== common/mpot_pkg.sv ====
// Purpose: shared constants and types of the motorized potentiometer
// Assumes: 100 MHz aclk, AXI4-Lite register access, rpm as signed 16-bit
// Notes:   ramp times are held in milliseconds
package mpot_pkg;
   // ==========================================================
   // register map (byte addresses)
   localparam logic [7:0] A_CFG    = 8'h00;
   localparam logic [7:0] A_RUP    = 8'h04;
   localparam logic [7:0] A_RDN    = 8'h08;
   localparam logic [7:0] A_START  = 8'h0c;
   localparam logic [7:0] A_UPPER  = 8'h10;
   localparam logic [7:0] A_LOWER  = 8'h14;
   localparam logic [7:0] A_DMAX   = 8'h18;
   localparam logic [7:0] A_SRC    = 8'h1c;
   localparam logic [7:0] A_PRESET = 8'h20;
   localparam logic [7:0] A_MAIN   = 8'h24;
   localparam logic [7:0] A_STAT   = 8'h28;
   localparam logic [7:0] A_NV     = 8'h2c;
   // ==========================================================
   // option word, bit 0 is retain
   typedef struct packed {
      logic always_calc;
      logic nv_store;
      logic rounding;
      logic auto_ramp;
      logic retain;
   } mpot_opts_t;
   localparam mpot_opts_t OPTS_RST = 5'h06;
   // signal source selectors, four bits each
   typedef struct packed {
      logic [3:0] preset;
      logic [3:0] swap;
      logic [3:0] lower;
      logic [3:0] raise;
   } mpot_src_t;
   localparam mpot_src_t  SRC_RST    = 16'h0000;
   localparam logic [3:0] SRC_ZERO   = 4'h0;
   localparam logic [3:0] SRC_DI0    = 4'h1;
   localparam logic [3:0] SRC_DI_LAST = 4'h8;
   localparam logic [3:0] SRC_KEY_UP = 4'h9;
   localparam logic [3:0] SRC_KEY_DN = 4'ha;
   localparam logic [3:0] SRC_ONE    = 4'hb;
   // ==========================================================
   // reset values and timing
   localparam int          RAMP_DEF_S   = 10;
   localparam int          MS_PER_S     = 1000;
   localparam logic [15:0] RAMP_RST     = 16'(RAMP_DEF_S * MS_PER_S);
   localparam logic [15:0] START_RST    = 16'h0000;
   localparam logic [15:0] UPPER_RST    = 16'h0000;
   localparam logic [15:0] LOWER_RST    = 16'h0000;
   localparam logic [15:0] PRESET_RST   = 16'h0000;
   localparam logic [15:0] DMAX_RST     = 16'h05dc;
   localparam logic [15:0] MAIN_RST     = 16'h0000;
   localparam logic [15:0] MAIN_SEL_MOP = 16'h041a;
   localparam int          CLK_NS       = 10;
   localparam int          MS_NS        = 1000000;
   localparam int          TICK_CYC     = MS_NS / CLK_NS;
   localparam logic [15:0] ROUND_PHASE_MS = 16'h0064;
   localparam logic [1:0]  ROUND_SHIFT_MAX = 2'h3;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   typedef enum logic [1:0] {
      DIR_HOLD = 2'b00,
      DIR_UP   = 2'b01,
      DIR_DN   = 2'b10
   } mpot_dir_t;
endpackage : mpot_pkg

// ==== rtl/mpot_top.sv ====
// Purpose: motorized potentiometer setpoint generator with AXI4-Lite regs
// Assumes: all inputs synchronous to aclk; nv image supplied by the system
// Notes:   setpoint moves 1 rpm per step, credit refilled every ms
// ==========================================================
// Summary of operation
// - raise command ramps setpoint up, 10 s default
// - lower command ramps setpoint down, 10 s default
// - rate equals max speed over ramp time
// - switch-on loads start value unless retaining
// - option word resets to binary 00110
// - bit 0 keeps setpoint across switch-off
// - auto mode, bit 1 clear: immediate change
// - mode input high auto, manual ramps unless ramp time is 0
// - bit 2 gives progressive initial rounding
// - bits 3 and 0 save setpoint nonvolatile
// - bit 4 clear: update only with pulses
// - raise source selectable, default constant zero
// - lower source selectable, default constant zero
// - setpoint never above upper limit unless lower limit is higher
// - setpoint never below lower limit
// - selectable source swaps the two limits
// - selectable source loads the preset value
// - output routed when main select is 1050
// - start value becomes setpoint at switch-on, bit 0 clear
`timescale 1ns/1ps
module mpot_top #(
   parameter int TICK_CYC = mpot_pkg::TICK_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [7:0]  digital_in,
   input  wire logic        panel_key_up,
   input  wire logic        panel_key_down,
   input  wire logic        auto_manual_select,
   input  wire logic        motor_on,
   input  wire logic        pulse_enable,
   input  wire logic        nv_valid,
   input  wire logic [15:0] nv_value,
   output logic [15:0]      setpoint,
   output logic [15:0]      main_setpoint,
   output logic             nv_save,
   output logic [15:0]      nv_data
);
   // ==========================================================
   // functions
   function automatic logic pick(input logic [3:0] code, input logic [7:0] di,
                                 input logic up, input logic dn);
      logic r;
      r = 1'b0;
      if (code >= mpot_pkg::SRC_DI0 && code <= mpot_pkg::SRC_DI_LAST) begin
         r = di[3'(code - mpot_pkg::SRC_DI0)];
      end else if (code == mpot_pkg::SRC_KEY_UP) begin
         r = up;
      end else if (code == mpot_pkg::SRC_KEY_DN) begin
         r = dn;
      end else if (code == mpot_pkg::SRC_ONE) begin
         r = 1'b1;
      end
      return r;
   endfunction : pick

   function automatic logic signed [15:0] clamp(input logic signed [15:0] v,
                                                input logic signed [15:0] lo,
                                                input logic signed [15:0] hi);
      logic signed [15:0] r;
      r = v;
      if (r > hi) begin
         r = hi;
      end
      if (r < lo) begin
         r = lo;
      end
      return r;
   endfunction : clamp

   // ==========================================================
   // registers
   mpot_pkg::mpot_opts_t opts_q;
   mpot_pkg::mpot_src_t  src_q;
   logic [15:0] rup_q, rdn_q, start_q, upper_q, lower_q, dmax_q, preset_q, main_sel_q;
   logic signed [15:0] sp_q, sp_d, retained_q;
   logic [31:0] credit_q;
   logic [31:0] tick_q;
   logic [15:0] held_ms_q;
   logic [1:0]  shift_q;
   logic        motor_on_q, preset_q1, nv_seen_q;
   logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [15:0] main_q, nv_data_q;
   logic        nv_save_q;
   mpot_pkg::mpot_dir_t dir;

   // ==========================================================
   // command sources and limits
   wire raise_cmd  = pick(src_q.raise, digital_in, panel_key_up, panel_key_down);
   wire lower_cmd  = pick(src_q.lower, digital_in, panel_key_up, panel_key_down);
   wire swap_cmd   = pick(src_q.swap, digital_in, panel_key_up, panel_key_down);
   wire preset_cmd = pick(src_q.preset, digital_in, panel_key_up, panel_key_down);
   wire signed [15:0] hi = swap_cmd ? $signed(lower_q) : $signed(upper_q);
   wire signed [15:0] lo = swap_cmd ? $signed(upper_q) : $signed(lower_q);
   wire on_rise  = motor_on & ~motor_on_q;
   wire off_fall = ~motor_on & motor_on_q;
   wire preset_rise = preset_cmd & ~preset_q1;
   wire calc_en  = pulse_enable | opts_q.always_calc;
   // manual mode ramps unless the ramp time is 0, auto mode only with bit 1
   wire immediate = auto_manual_select & ~opts_q.auto_ramp;
   wire [15:0] ramp_ms = (dir == mpot_pkg::DIR_DN) ? rdn_q : rup_q;
   wire tick = (tick_q == 32'(TICK_CYC - 1));
   // rounding scales the refill by 1/8, 1/4, 1/2 then full
   wire [15:0] refill = opts_q.rounding ? (dmax_q >> shift_q) : dmax_q;
   wire step = (ramp_ms != 16'h0000) && (credit_q >= 32'(ramp_ms)) && !tick;

   // equal or absent commands hold the setpoint
   assign dir = (raise_cmd && !lower_cmd) ? mpot_pkg::DIR_UP :
                (lower_cmd && !raise_cmd) ? mpot_pkg::DIR_DN :
                mpot_pkg::DIR_HOLD;

   // ==========================================================
   // setpoint next value
   always_comb begin
      sp_d = sp_q;
      if (on_rise) begin
         sp_d = opts_q.retain ? retained_q : $signed(start_q);
      end else if (preset_rise) begin
         sp_d = $signed(preset_q);
      end else if (calc_en) begin
         case (dir)
            mpot_pkg::DIR_UP: begin
               if (immediate || rup_q == 16'h0000) begin
                  sp_d = hi;
               end else if (step && sp_q < hi) begin
                  sp_d = sp_q + 16'sh0001;
               end
            end
            mpot_pkg::DIR_DN: begin
               if (immediate || rdn_q == 16'h0000) begin
                  sp_d = lo;
               end else if (step && sp_q > lo) begin
                  sp_d = sp_q - 16'sh0001;
               end
            end
            default: begin
               sp_d = sp_q;
            end
         endcase
      end
      sp_d = clamp(sp_d, lo, hi);
   end

   // ==========================================================
   // ramp credit: each ms adds refill (dmax, scaled down while rounding), each step spends ramp_ms
   always_ff @(posedge aclk) begin
      if (!aresetn || dir == mpot_pkg::DIR_HOLD || !calc_en) begin
         credit_q  <= 32'h0000_0000;
         held_ms_q <= 16'h0000;
         shift_q   <= mpot_pkg::ROUND_SHIFT_MAX;
      end else if (tick) begin
         credit_q  <= credit_q + 32'(refill);
         held_ms_q <= (held_ms_q == mpot_pkg::ROUND_PHASE_MS) ? 16'h0000
                                                               : held_ms_q + 16'h0001;
         if (held_ms_q == mpot_pkg::ROUND_PHASE_MS && shift_q != 2'h0) begin
            shift_q <= shift_q - 2'h1;
         end
      end else if (step) begin
         credit_q <= credit_q - 32'(ramp_ms);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || tick) begin
         tick_q <= 32'h0000_0000;
      end else begin
         tick_q <= tick_q + 32'h0000_0001;
      end
   end

   // ==========================================================
   // setpoint, retention and outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sp_q       <= 16'sh0000;
         retained_q <= 16'sh0000;
         motor_on_q <= 1'b0;
         preset_q1  <= 1'b0;
         nv_seen_q  <= 1'b0;
         nv_save_q  <= 1'b0;
         nv_data_q  <= 16'h0000;
         main_q     <= 16'h0000;
      end else begin
         sp_q       <= sp_d;
         motor_on_q <= motor_on;
         preset_q1  <= preset_cmd;
         nv_save_q  <= 1'b0;
         // nv image is taken once, after reset release
         if (nv_valid && !nv_seen_q) begin
            nv_seen_q  <= 1'b1;
            retained_q <= $signed(nv_value);
         end else if (off_fall) begin
            retained_q <= sp_q;
         end
         if (off_fall && opts_q.retain && opts_q.nv_store) begin
            nv_save_q <= 1'b1;
            nv_data_q <= sp_q;
         end
         main_q <= (main_sel_q == mpot_pkg::MAIN_SEL_MOP) ? sp_q : 16'h0000;
      end
   end

   assign setpoint      = sp_q;
   assign main_setpoint = main_q;
   assign nv_save       = nv_save_q;
   assign nv_data       = nv_data_q;

   // ==========================================================
   // AXI4-Lite write channel
   wire wr_fire = !awready_q && !wready_q && !bvalid_q;
   wire [15:0] wlo = wdata_q[15:0];
   wire wr_hit = (awaddr_q <= mpot_pkg::A_MAIN) && (awaddr_q[1:0] == 2'h0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= mpot_pkg::RESP_OKAY;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
      end else begin
         if (awready_q && s_axi_awvalid) begin
            awready_q <= 1'b0;
            awaddr_q  <= s_axi_awaddr;
         end
         if (wready_q && s_axi_wvalid) begin
            wready_q <= 1'b0;
            wdata_q  <= s_axi_wdata;
         end
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? mpot_pkg::RESP_OKAY : mpot_pkg::RESP_SLVERR;
         end
         if (bvalid_q && s_axi_bready) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // byte strobes ignored: every field fits the low half-word
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         opts_q     <= mpot_pkg::OPTS_RST;
         rup_q      <= mpot_pkg::RAMP_RST;
         rdn_q      <= mpot_pkg::RAMP_RST;
         start_q    <= mpot_pkg::START_RST;
         upper_q    <= mpot_pkg::UPPER_RST;
         lower_q    <= mpot_pkg::LOWER_RST;
         dmax_q     <= mpot_pkg::DMAX_RST;
         src_q      <= mpot_pkg::SRC_RST;
         preset_q   <= mpot_pkg::PRESET_RST;
         main_sel_q <= mpot_pkg::MAIN_RST;
      end else if (wr_fire) begin
         if (awaddr_q == mpot_pkg::A_CFG) begin
            opts_q <= wlo[4:0];
         end else if (awaddr_q == mpot_pkg::A_RUP) begin
            rup_q <= wlo;
         end else if (awaddr_q == mpot_pkg::A_RDN) begin
            rdn_q <= wlo;
         end else if (awaddr_q == mpot_pkg::A_START) begin
            start_q <= wlo;
         end else if (awaddr_q == mpot_pkg::A_UPPER) begin
            upper_q <= wlo;
         end else if (awaddr_q == mpot_pkg::A_LOWER) begin
            lower_q <= wlo;
         end else if (awaddr_q == mpot_pkg::A_DMAX) begin
            dmax_q <= wlo;
         end else if (awaddr_q == mpot_pkg::A_SRC) begin
            src_q <= wlo;
         end else if (awaddr_q == mpot_pkg::A_PRESET) begin
            preset_q <= wlo;
         end else if (awaddr_q == mpot_pkg::A_MAIN) begin
            main_sel_q <= wlo;
         end
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   logic [31:0] rd_mux;
   logic        rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      if (s_axi_araddr == mpot_pkg::A_CFG) begin
         rd_mux = {27'h0, opts_q};
      end else if (s_axi_araddr == mpot_pkg::A_RUP) begin
         rd_mux = {16'h0, rup_q};
      end else if (s_axi_araddr == mpot_pkg::A_RDN) begin
         rd_mux = {16'h0, rdn_q};
      end else if (s_axi_araddr == mpot_pkg::A_START) begin
         rd_mux = {16'h0, start_q};
      end else if (s_axi_araddr == mpot_pkg::A_UPPER) begin
         rd_mux = {16'h0, upper_q};
      end else if (s_axi_araddr == mpot_pkg::A_LOWER) begin
         rd_mux = {16'h0, lower_q};
      end else if (s_axi_araddr == mpot_pkg::A_DMAX) begin
         rd_mux = {16'h0, dmax_q};
      end else if (s_axi_araddr == mpot_pkg::A_SRC) begin
         rd_mux = {16'h0, src_q};
      end else if (s_axi_araddr == mpot_pkg::A_PRESET) begin
         rd_mux = {16'h0, preset_q};
      end else if (s_axi_araddr == mpot_pkg::A_MAIN) begin
         rd_mux = {16'h0, main_sel_q};
      end else if (s_axi_araddr == mpot_pkg::A_STAT) begin
         rd_mux = {11'h0, motor_on_q, swap_cmd, lower_cmd, raise_cmd, calc_en, sp_q};
      end else if (s_axi_araddr == mpot_pkg::A_NV) begin
         rd_mux = {16'h0, retained_q};
      end else begin
         rd_mux = 32'h0000_0000;
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= mpot_pkg::RESP_OKAY;
      end else if (arready_q && s_axi_arvalid) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_mux;
         rresp_q   <= rd_hit ? mpot_pkg::RESP_OKAY : mpot_pkg::RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // ==========================================================
   // assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire quiet = !on_rise && !preset_rise && (sp_q >= lo) && (sp_q <= hi);

   a_upper_bound: assert property ($past(lo) <= $past(hi) |-> sp_q <= $past(hi))
      else $error("setpoint above upper limit");
   a_lower_bound: assert property (##1 sp_q >= $past(lo))
      else $error("setpoint below lower limit");
   a_switch_start: assert property (on_rise && !opts_q.retain && lo <= hi
      |=> sp_q == clamp($signed($past(start_q)), $past(lo), $past(hi)))
      else $error("start value not loaded at switch-on");
   a_switch_retain: assert property (on_rise && opts_q.retain && lo <= hi
      |=> sp_q == clamp($past(retained_q), $past(lo), $past(hi)))
      else $error("retained setpoint not restored");
   a_hold_equal: assert property (quiet && dir == mpot_pkg::DIR_HOLD |=> $stable(sp_q))
      else $error("setpoint moved without single command");
   a_pulse_gate: assert property (quiet && !calc_en |=> $stable(sp_q))
      else $error("setpoint moved without pulse enable");
   a_auto_jump: assert property (quiet && calc_en && immediate && dir == mpot_pkg::DIR_UP
      |=> sp_q == $past(hi))
      else $error("auto mode without ramp did not jump");
   a_manual_ramp: assert property (quiet && calc_en && !auto_manual_select && !step
      && rup_q != 16'h0000 && rdn_q != 16'h0000 |=> $stable(sp_q))
      else $error("manual mode moved without ramp step");
   a_nv_save: assert property (off_fall && opts_q.retain && opts_q.nv_store
      |=> nv_save && nv_data == $past(sp_q))
      else $error("nonvolatile save missing");
   a_main_route: assert property (main_sel_q == mpot_pkg::MAIN_SEL_MOP ##1
      main_sel_q == mpot_pkg::MAIN_SEL_MOP |-> main_setpoint == $past(sp_q))
      else $error("main setpoint not routed");
   a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");

   c_ramp_up: cover property (calc_en && step && dir == mpot_pkg::DIR_UP);
   c_ramp_down: cover property (calc_en && step && dir == mpot_pkg::DIR_DN);
   c_swap: cover property (swap_cmd && upper_q != lower_q);
   c_restore: cover property (on_rise && opts_q.retain);
endmodule : mpot_top

// ==== verif/mpot_panel_model.sv ====
// Purpose: stand-in for the terminal strip and panel keys
// Assumes: bench commands are levels, sampled on aclk
// Notes:   unused terminals read low, as an open input does
`timescale 1ns/1ps
module mpot_panel_model (
   input  wire logic  aclk,
   input  wire logic  up,
   input  wire logic  dn,
   input  wire logic  pre,
   input  wire logic  keys,
   output logic [7:0] digital_in = 8'h00,
   output logic       panel_key_up = 1'b0,
   output logic       panel_key_down = 1'b0
);
   // ==========================================================
   // command routing, one register stage like a real input filter
   always_ff @(posedge aclk) begin
      digital_in     <= {5'h00, pre, dn & ~keys, up & ~keys};
      panel_key_up   <= up & keys;
      panel_key_down <= dn & keys;
   end
endmodule : mpot_panel_model

// ==== verif/motorized_pot_setpoint_generator_test.sv ====
// Purpose: self-checking bench of the motorized potentiometer
// Assumes: tick shortened to TK cycles; model adds one cycle of latency
// Notes:   ramp results checked in bands, tick phase is not aligned
`timescale 1ns/1ps
module motorized_pot_setpoint_generator_test;
   localparam int TK = 20;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, digital_in;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, panel_key_up, panel_key_down;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic        auto_manual_select = 1'b0, motor_on = 1'b0, pulse_enable = 1'b1;
   logic        nv_valid = 1'b1, up = 1'b0, dn = 1'b0, pre = 1'b0, keys = 1'b0;
   logic        nv_save, saw;
   logic [15:0] nv_value = 16'h0007, setpoint, main_setpoint, nv_data, sp0, dl;
   logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
   logic [31:0] rv [7] = '{32'h6, 32'h2710, 32'h2710, 32'h0, 32'h0, 32'h0, 32'h0};
   int          failures = 0, checked = 0;
   // ==========================================================
   // design and far side
   mpot_top #(.TICK_CYC(TK)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .digital_in, .panel_key_up,
      .panel_key_down, .auto_manual_select, .motor_on, .pulse_enable, .nv_valid, .nv_value,
      .setpoint, .main_setpoint, .nv_save, .nv_data);
   mpot_panel_model panel (.aclk, .up, .dn, .pre, .keys, .digital_in, .panel_key_up,
      .panel_key_down);
   always #5 aclk = ~aclk;
   // ==========================================================
   // tasks
   task automatic cy(input int n);
      repeat (n) @(posedge aclk);
   endtask : cy
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // starts on a fresh edge so a strobe is never assigned twice in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      resp = s_axi_bresp;
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      rd   = s_axi_rdata;
      resp = s_axi_rresp;
   endtask : rdr
   task automatic end_of_test();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test
   // ==========================================================
   // tests
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rdr(ra[i]);
         chk(rd, rv[i]);
      end
      rdr(8'h30);
      chk({30'h0, resp}, {30'h0, mpot_pkg::RESP_SLVERR});
      $display("test reset values done");
      wr(mpot_pkg::A_DMAX, 32'h64);
      wr(mpot_pkg::A_RUP, 32'h0a);
      wr(mpot_pkg::A_RDN, 32'h05);
      wr(mpot_pkg::A_UPPER, 32'hc8);
      wr(mpot_pkg::A_LOWER, 32'h05);
      wr(mpot_pkg::A_START, 32'h0a);
      wr(mpot_pkg::A_SRC, 32'h0321);
      wr(mpot_pkg::A_PRESET, 32'h21);
      wr(mpot_pkg::A_MAIN, {16'h0, mpot_pkg::MAIN_SEL_MOP});
      wr(mpot_pkg::A_CFG, 32'h01);
      chk({30'h0, resp}, {30'h0, mpot_pkg::RESP_OKAY});
      motor_on <= 1'b1;
      cy(5);
      chk({16'h0, setpoint}, 32'h7);
      chk({16'h0, main_setpoint}, 32'h7);
      wr(mpot_pkg::A_CFG, 32'h00);
      motor_on <= 1'b0;
      cy(5);
      motor_on <= 1'b1;
      cy(5);
      chk({16'h0, setpoint}, 32'h0a);
      $display("test switch-on done");
      up <= 1'b1;
      cy(8 * TK);
      up <= 1'b0;
      cy(5);
      dl = setpoint - 16'h0a;
      chk({31'h0, dl >= 16'h3c && dl <= 16'h5a}, 32'h1);
      sp0 = setpoint;
      up <= 1'b1;
      dn <= 1'b1;
      cy(3 * TK);
      chk({16'h0, setpoint}, {16'h0, sp0});
      up <= 1'b0;
      cy(2 * TK);
      dn <= 1'b0;
      cy(5);
      dl = sp0 - setpoint;
      chk({31'h0, dl >= 16'h0f && dl <= 16'h2d}, 32'h1);
      $display("test ramps done");
      pulse_enable <= 1'b0;
      up <= 1'b1;
      sp0 = setpoint;
      cy(3 * TK);
      chk({16'h0, setpoint}, {16'h0, sp0});
      wr(mpot_pkg::A_CFG, 32'h10);
      cy(2 * TK);
      up <= 1'b0;
      chk({31'h0, setpoint > sp0}, 32'h1);
      pulse_enable <= 1'b1;
      wr(mpot_pkg::A_SRC, 32'h03a9);
      keys <= 1'b1;
      auto_manual_select <= 1'b1;
      up <= 1'b1;
      cy(5);
      chk({16'h0, setpoint}, 32'hc8);
      up <= 1'b0;
      dn <= 1'b1;
      cy(5);
      chk({16'h0, setpoint}, 32'h05);
      dn <= 1'b0;
      auto_manual_select <= 1'b0;
      up <= 1'b1;
      cy(5);
      up <= 1'b0;
      chk({31'h0, setpoint < 16'h1e}, 32'h1);
      $display("test modes done");
      wr(mpot_pkg::A_SRC, 32'h0ba9);
      cy(5);
      chk({16'h0, setpoint}, 32'hc8);
      // preset now on the terminal that fed the swap, so pre cannot swap too
      wr(mpot_pkg::A_SRC, 32'h30a9);
      pre <= 1'b1;
      cy(5);
      pre <= 1'b0;
      chk({16'h0, setpoint}, 32'h21);
      wr(mpot_pkg::A_MAIN, 32'h0);
      cy(5);
      chk({16'h0, main_setpoint}, 32'h0);
      wr(mpot_pkg::A_CFG, 32'h19);
      motor_on <= 1'b0;
      saw = 1'b0;
      repeat (6) begin
         @(posedge aclk);
         if (nv_save === 1'b1) saw = 1'b1;
      end
      chk({31'h0, saw}, 32'h1);
      chk({16'h0, nv_data}, 32'h21);
      rdr(mpot_pkg::A_NV);
      chk(rd, 32'h21);
      motor_on <= 1'b1;
      cy(5);
      chk({16'h0, setpoint}, 32'h21);
      rdr(mpot_pkg::A_STAT);
      chk(rd, 32'h0011_0021);
      $display("test limits and retain done");
      wr(mpot_pkg::A_CFG, 32'h14);
      sp0 = setpoint;
      up <= 1'b1;
      cy(4 * TK);
      up <= 1'b0;
      cy(5);
      dl = setpoint - sp0;
      chk({31'h0, dl >= 16'h1 && dl <= 16'h8}, 32'h1);
      $display("test rounding done");
      end_of_test();
   end
   // the tests need about 620 cycles; eight times that means a hang
   initial begin
      repeat (5000) @(posedge aclk);
      failures++;
      end_of_test();
   end
endmodule : motorized_pot_setpoint_generator_test
